// ### hw/qsf_pin_io.sv
// Function
// - Single-line mode samples input lane 0 on every rising serial clock edge.
// - Single-line mode drives read data on lane 1, updated on falling edges.
// - Multi-lane modes use bidirectional lanes: host in on rise, device out on fall.
// - Quad and four-lane operation is accepted only while quad lanes enable is set.
// - With quad lanes enable clear, write-guard pin is lane 2, pause pin lane 3.
// - Active-low write-guard, when available, blocks status register writes.
// - With quad lanes enable set, the write-guard function is ignored.
// - Pause low while selected floats the output and ignores input and clock.
// - Pause returning high resumes the interrupted transfer where it stopped.
// - With quad lanes enable set, the pause function is not performed.
// - Active-low hardware reset pin, when available, resets the device; here it aborts only map and program work.
// - With quad lanes enable clear, lane 3 pin is pause or reset by setting.
// - With quad lanes enable set, both pause and reset functions are off.
// - Array is 65,536 pages of 256 bytes each.
// - One program writes at most 256 bytes and only clears bits.
// - Erase units are 4 KB sector, 32 KB block, 64 KB block, whole array.
// - There are 4,096 sectors, 512 32 KB blocks and 256 64 KB blocks.
// - While chip select is high all output lanes float.
`timescale 1ns/1ns
`default_nettype none
module qsf_pin_io
  import qsf_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sclk, // Serial clock from the host
  input wire logic csN, // Chip select, active low
  input wire logic ioLane0In, // Lane 0 pin level
  output logic ioLane0Out, // Lane 0 drive value
  output logic ioLane0Oe, // Lane 0 drive enable
  input wire logic ioLane1In, // Lane 1 pin level
  output logic ioLane1Out, // Lane 1 drive value
  output logic ioLane1Oe, // Lane 1 drive enable
  input wire logic ioLane2In, // Lane 2 or write-guard pin level
  output logic ioLane2Out, // Lane 2 drive value
  output logic ioLane2Oe, // Lane 2 drive enable
  input wire logic ioLane3In, // Lane 3, pause or reset pin level
  output logic ioLane3Out, // Lane 3 drive value
  output logic ioLane3Oe, // Lane 3 drive enable
  input wire logic quadLanesEnable, // Non-volatile quad lanes enable bit
  input wire logic holdSelect, // Lane 3 pin: 1 pause, 0 hardware reset
  input wire logic fourLaneCommandMode, // Commands arrive on four lanes
  input wire logic wordValid, // Post one slot word toward the link
  input wire logic [7:0] wordData, // Byte to send in that slot
  input wire qsf_pkg::qsf_width_t wordWidth, // Lane width of that slot
  input wire logic wordDrive, // Device drives lanes in that slot
  output logic wordReady, // Slot word may be posted
  output logic wordRefused, // Posted word refused or clamped
  output logic rxValid, // A received byte is ready
  output logic [7:0] rxByte, // The received byte
  output logic frameActive, // Chip select seen low
  input wire logic statusWrReq, // Core asks to write status registers
  output logic statusWrGrant, // Status write allowed
  output logic statusWrDenied, // Status write blocked by the guard pin
  output logic statusWrBlocked, // Guard currently blocking
  output logic deviceReset, // Hardware reset pin in effect
  input wire logic mapValid, // Decode an erase target
  input wire logic [qsf_pkg::ADDR_W-1:0] mapAddr, // Byte address to decode
  input wire qsf_pkg::qsf_erase_t mapKind, // Erase unit to decode
  output logic mapDone, // Decoded outputs updated
  output logic [qsf_pkg::PAGE_IDX_W-1:0] pageIndex, // Page number
  output logic [qsf_pkg::SECTOR_IDX_W-1:0] sectorIndex, // Sector number
  output logic [qsf_pkg::BLK32_IDX_W-1:0] blk32Index, // 32 KB block number
  output logic [qsf_pkg::BLK64_IDX_W-1:0] blk64Index, // 64 KB block number
  output logic [qsf_pkg::ADDR_W-1:0] eraseBase, // First byte of erase unit
  output logic [qsf_pkg::ADDR_W-1:0] eraseLast, // Last byte of erase unit
  input wire logic progStart, // Begin a program operation
  input wire logic [qsf_pkg::ADDR_W-1:0] progAddr, // Program start address
  input wire logic progByteValid, // One data byte to program
  input wire logic [7:0] progOld, // Current array byte
  input wire logic [7:0] progNew, // Byte the host wrote
  output logic progOutValid, // Merged byte ready
  output logic [7:0] progMerged, // Byte to store
  output logic [qsf_pkg::ADDR_W-1:0] progOutAddr, // Where to store it
  output logic progRefused // Byte beyond the program limit
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [BEAT_W-1:0] beatLast(qsf_width_t w);
    beatLast = (w == QSF_W4) ? BEAT_LAST_W4 : (w == QSF_W2) ? BEAT_LAST_W2 : BEAT_LAST_W1;
  endfunction

  function automatic logic [7:0] shiftIn(logic [7:0] s, logic [3:0] pins, qsf_width_t w);
    shiftIn = (w == QSF_W4) ? {s[3:0], pins} :
              (w == QSF_W2) ? {s[5:0], pins[1:0]} : {s[6:0], pins[0]};
  endfunction

  function automatic logic [3:0] txBits(logic [7:0] d, logic [BEAT_W-1:0] b, qsf_width_t w);
    logic [7:0] sh;
    if (w == QSF_W4)
      sh = d << {b[0], 2'h0};
    else if (w == QSF_W2)
      sh = d << {b[1:0], 1'h0};
    else
      sh = d << b;
    txBits = (w == QSF_W4) ? sh[7:4] : (w == QSF_W2) ? {2'h0, sh[7:6]} : {2'h0, sh[7], 1'h0};
  endfunction

  function automatic logic [ADDR_W-1:0] alignDown(logic [ADDR_W-1:0] a, qsf_erase_t k);
    alignDown = (k == QSF_ERASE_SECTOR) ? {a[ADDR_W-1:SECTOR_SHIFT], {SECTOR_SHIFT{1'b0}}} :
                (k == QSF_ERASE_BLK32) ? {a[ADDR_W-1:BLK32_SHIFT], {BLK32_SHIFT{1'b0}}} :
                (k == QSF_ERASE_BLK64) ? {a[ADDR_W-1:BLK64_SHIFT], {BLK64_SHIFT{1'b0}}} :
                {ADDR_W{1'b0}};
  endfunction

  function automatic logic [ADDR_W-1:0] unitMask(qsf_erase_t k);
    unitMask = (k == QSF_ERASE_SECTOR) ? {{SECTOR_IDX_W{1'b0}}, {SECTOR_SHIFT{1'b1}}} :
               (k == QSF_ERASE_BLK32) ? {{BLK32_IDX_W{1'b0}}, {BLK32_SHIFT{1'b1}}} :
               (k == QSF_ERASE_BLK64) ? {{BLK64_IDX_W{1'b0}}, {BLK64_SHIFT{1'b1}}} :
               ADDR_LAST;
  endfunction

  // ****************************************************************
  // Quasi-static configuration, changed only while deselected
  // ****************************************************************
  logic qeCfg_r;
  logic holdSelCfg_r;
  logic fourLaneCfg_r;
  logic linkRstN_r;
  logic [1:0] csSync_r;
  logic csIdle;

  assign csIdle = csSync_r[1];

  // The link reads these directly; they move only while no frame runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      qeCfg_r <= RST_QE;
      holdSelCfg_r <= RST_HOLD_SEL;
      fourLaneCfg_r <= RST_FOUR_LANE;
    end
    else if (csIdle)
    begin
      qeCfg_r <= quadLanesEnable;
      holdSelCfg_r <= holdSelect;
      fourLaneCfg_r <= fourLaneCommandMode & quadLanesEnable;
    end
  end

  always_ff @(posedge clk)
  begin
    linkRstN_r <= rst_n;
    csSync_r <= rst_n ? {csSync_r[0], csN} : 2'h3;
  end

  // ****************************************************************
  // Link domain: capture on the rising serial clock edge
  // ****************************************************************
  logic [BEAT_W-1:0] beat_r;
  logic [7:0] shift_r;
  qsf_width_t curWidth_r;
  logic curDrive_r;
  logic [7:0] curData_r;
  logic [7:0] rxHold_r;
  logic rxTog_r;
  logic [1:0] txReqSync_r;
  logic txAck_r;
  logic txReq_r;
  logic [7:0] wordData_r;
  qsf_width_t wordWidth_r;
  logic wordDrive_r;
  logic holdFunc;
  logic holdNow;
  logic byteDone;
  logic newWord;
  logic [3:0] pinsIn;
  logic [7:0] shiftNxt;
  qsf_width_t startWidth;

  assign holdFunc = !qeCfg_r && holdSelCfg_r;
  assign holdNow = holdFunc && !ioLane3In;
  assign pinsIn = {ioLane3In, ioLane2In, ioLane1In, ioLane0In};
  assign shiftNxt = shiftIn(shift_r, pinsIn, curWidth_r);
  assign byteDone = !holdNow && (beat_r == beatLast(curWidth_r));
  assign newWord = txReqSync_r[1] != txAck_r;
  assign startWidth = fourLaneCfg_r ? QSF_W4 : QSF_W1;

  // Frame state restarts whenever chip select is high
  always_ff @(posedge sclk or posedge csN)
  begin
    if (csN)
    begin
      beat_r <= '0;
      shift_r <= 8'h00;
      curWidth_r <= QSF_W1;
      curDrive_r <= 1'b0;
      curData_r <= IDLE_BYTE;
    end
    else if (!holdNow)
    begin
      shift_r <= shiftNxt;
      beat_r <= byteDone ? '0 : beat_r + 3'h1;
      if (beat_r == '0 && shift_r == 8'h00 && curData_r == IDLE_BYTE && !curDrive_r)
        curWidth_r <= startWidth;
      if (byteDone)
      begin
        curWidth_r <= newWord ? wordWidth_r : curWidth_r;
        curDrive_r <= newWord && wordDrive_r;
        curData_r <= newWord ? wordData_r : IDLE_BYTE;
      end
    end
  end

  // Handshake state survives chip select so no event is lost across frames
  always_ff @(posedge sclk or negedge linkRstN_r)
  begin
    if (!linkRstN_r)
    begin
      rxHold_r <= 8'h00;
      rxTog_r <= 1'b0;
      txReqSync_r <= 2'h0;
      txAck_r <= 1'b0;
    end
    else
    begin
      txReqSync_r <= {txReqSync_r[0], txReq_r};
      if (!csN && byteDone)
      begin
        rxHold_r <= shiftNxt;
        rxTog_r <= !rxTog_r;
        txAck_r <= txReqSync_r[1];
      end
    end
  end

  // ****************************************************************
  // Link domain: drive on the falling serial clock edge
  // ****************************************************************
  logic [3:0] laneOut_r;
  logic [3:0] laneOe_r;
  logic [3:0] oeSel;

  assign oeSel = (curWidth_r == QSF_W4) ? OE_W4 : (curWidth_r == QSF_W2) ? OE_W2 : OE_W1;

  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      laneOut_r <= 4'h0;
      laneOe_r <= 4'h0;
    end
    else
    begin
      laneOut_r <= txBits(curData_r, beat_r, curWidth_r);
      laneOe_r <= (curDrive_r && !holdNow) ? oeSel : 4'h0;
    end
  end

  assign {ioLane3Out, ioLane2Out, ioLane1Out, ioLane0Out} = laneOut_r;
  assign {ioLane3Oe, ioLane2Oe, ioLane1Oe, ioLane0Oe} = laneOe_r;

  // ****************************************************************
  // Word crossing from the core into the link
  // ****************************************************************
  logic [1:0] ackSync_r;
  logic wordReady_r;
  logic wordRefused_r;
  logic wordTake;
  logic wideRefused;

  assign wordTake = wordValid && wordReady_r && !csIdle;
  assign wideRefused = (wordWidth == QSF_W4) && !qeCfg_r;

  // Word registers stay frozen until the link returns the toggle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ackSync_r <= 2'h0;
      txReq_r <= 1'b0;
      wordData_r <= IDLE_BYTE;
      wordWidth_r <= QSF_W1;
      wordDrive_r <= 1'b0;
      wordReady_r <= 1'b0;
      wordRefused_r <= 1'b0;
    end
    else
    begin
      ackSync_r <= {ackSync_r[0], txAck_r};
      wordReady_r <= (txReq_r == ackSync_r[1]) && !wordTake;
      wordRefused_r <= wordValid && (!wordTake || wideRefused);
      if (wordTake)
      begin
        txReq_r <= !txReq_r;
        wordData_r <= wordData;
        wordWidth_r <= wideRefused ? QSF_W1 : wordWidth;
        wordDrive_r <= wordDrive;
      end
    end
  end

  assign wordReady = wordReady_r;
  assign wordRefused = wordRefused_r;

  // ****************************************************************
  // Received bytes into the core
  // ****************************************************************
  logic [2:0] rxSync_r;
  logic rxValid_r;
  logic [7:0] rxByte_r;
  logic frameActive_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxSync_r <= 3'h0;
      rxValid_r <= 1'b0;
      rxByte_r <= 8'h00;
      frameActive_r <= 1'b0;
    end
    else
    begin
      rxSync_r <= {rxSync_r[1:0], rxTog_r};
      rxValid_r <= rxSync_r[2] != rxSync_r[1];
      frameActive_r <= !csIdle;
      if (rxSync_r[2] != rxSync_r[1])
        rxByte_r <= rxHold_r;
    end
  end

  assign rxValid = rxValid_r;
  assign rxByte = rxByte_r;
  assign frameActive = frameActive_r;

  // ****************************************************************
  // Write-guard and hardware reset pin functions
  // ****************************************************************
  logic [1:0] guardSync_r;
  logic [1:0] rstPinSync_r;
  logic guardOn;
  logic resetFunc;
  logic statusWrGrant_r;
  logic statusWrDenied_r;
  logic statusWrBlocked_r;
  logic deviceReset_r;

  // Lane pins are data while quad lanes are enabled, so the functions drop out
  assign guardOn = !qeCfg_r && !guardSync_r[1];
  assign resetFunc = !qeCfg_r && !holdSelCfg_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      guardSync_r <= 2'h3;
      rstPinSync_r <= 2'h3;
      statusWrGrant_r <= 1'b0;
      statusWrDenied_r <= 1'b0;
      statusWrBlocked_r <= 1'b0;
      deviceReset_r <= 1'b0;
    end
    else
    begin
      guardSync_r <= {guardSync_r[0], ioLane2In};
      rstPinSync_r <= {rstPinSync_r[0], ioLane3In};
      statusWrGrant_r <= statusWrReq && !guardOn;
      statusWrDenied_r <= statusWrReq && guardOn;
      statusWrBlocked_r <= guardOn;
      deviceReset_r <= resetFunc && !rstPinSync_r[1];
    end
  end

  assign statusWrGrant = statusWrGrant_r;
  assign statusWrDenied = statusWrDenied_r;
  assign statusWrBlocked = statusWrBlocked_r;
  assign deviceReset = deviceReset_r;

  // ****************************************************************
  // Array map and program merge
  // ****************************************************************
  logic opRst;
  logic mapDone_r;
  logic [PAGE_IDX_W-1:0] pageIndex_r;
  logic [SECTOR_IDX_W-1:0] sectorIndex_r;
  logic [BLK32_IDX_W-1:0] blk32Index_r;
  logic [BLK64_IDX_W-1:0] blk64Index_r;
  logic [ADDR_W-1:0] eraseBase_r;
  logic [ADDR_W-1:0] eraseLast_r;
  logic [ADDR_W-1:0] progBase_r;
  logic [PROG_CNT_W-1:0] progCnt_r;
  logic progOutValid_r;
  logic [7:0] progMerged_r;
  logic [ADDR_W-1:0] progOutAddr_r;
  logic progRefused_r;
  logic progRoom;
  logic [ADDR_W-1:0] eraseBaseNxt;
  logic [7:0] progOffset;

  // A hardware reset aborts map and program work, never the pin handshakes
  assign opRst = !rst_n || deviceReset_r;
  assign progRoom = progCnt_r != PROG_CNT_MAX;
  assign eraseBaseNxt = alignDown(mapAddr, mapKind);
  // Offset wraps inside the page, as a program never crosses a page edge
  assign progOffset = progBase_r[PAGE_SHIFT-1:0] + progCnt_r[PAGE_SHIFT-1:0];

  always_ff @(posedge clk)
  begin
    if (opRst)
    begin
      mapDone_r <= 1'b0;
      pageIndex_r <= '0;
      sectorIndex_r <= '0;
      blk32Index_r <= '0;
      blk64Index_r <= '0;
      eraseBase_r <= '0;
      eraseLast_r <= '0;
    end
    else
    begin
      mapDone_r <= mapValid;
      if (mapValid)
      begin
        pageIndex_r <= mapAddr[ADDR_W-1:PAGE_SHIFT];
        sectorIndex_r <= mapAddr[ADDR_W-1:SECTOR_SHIFT];
        blk32Index_r <= mapAddr[ADDR_W-1:BLK32_SHIFT];
        blk64Index_r <= mapAddr[ADDR_W-1:BLK64_SHIFT];
        eraseBase_r <= eraseBaseNxt;
        eraseLast_r <= eraseBaseNxt | unitMask(mapKind);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (opRst)
    begin
      progBase_r <= '0;
      progCnt_r <= PROG_CNT_MAX;
      progOutValid_r <= 1'b0;
      progMerged_r <= 8'hff;
      progOutAddr_r <= '0;
      progRefused_r <= 1'b0;
    end
    else
    begin
      progOutValid_r <= progByteValid && progRoom && !progStart;
      progRefused_r <= progByteValid && !progRoom && !progStart;
      if (progStart)
      begin
        progBase_r <= progAddr;
        progCnt_r <= '0;
      end
      else if (progByteValid && progRoom)
      begin
        progMerged_r <= progOld & progNew;
        progOutAddr_r <= {progBase_r[ADDR_W-1:PAGE_SHIFT], progOffset};
        progCnt_r <= progCnt_r + 9'h001;
      end
    end
  end

  assign mapDone = mapDone_r;
  assign pageIndex = pageIndex_r;
  assign sectorIndex = sectorIndex_r;
  assign blk32Index = blk32Index_r;
  assign blk64Index = blk64Index_r;
  assign eraseBase = eraseBase_r;
  assign eraseLast = eraseLast_r;
  assign progOutValid = progOutValid_r;
  assign progMerged = progMerged_r;
  assign progOutAddr = progOutAddr_r;
  assign progRefused = progRefused_r;

endmodule
`default_nettype wire

// ### hw/qsf_pkg.sv
package qsf_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned PAGE_SHIFT = 8;
  localparam int unsigned SECTOR_SHIFT = 12;
  localparam int unsigned BLK32_SHIFT = 15;
  localparam int unsigned BLK64_SHIFT = 16;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned PAGE_COUNT = 65536;
  localparam int unsigned SECTOR_COUNT = 4096;
  localparam int unsigned BLK32_COUNT = 512;
  localparam int unsigned BLK64_COUNT = 256;
  localparam int unsigned PAGE_IDX_W = ADDR_W - PAGE_SHIFT;
  localparam int unsigned SECTOR_IDX_W = ADDR_W - SECTOR_SHIFT;
  localparam int unsigned BLK32_IDX_W = ADDR_W - BLK32_SHIFT;
  localparam int unsigned BLK64_IDX_W = ADDR_W - BLK64_SHIFT;
  localparam int unsigned PROG_CNT_W = PAGE_SHIFT + 1;
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_MAX = 9'h100;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 24'hffffff;

  // ****************************************************************
  // Link framing
  // ****************************************************************
  localparam int unsigned BEAT_W = 3;
  localparam logic [BEAT_W-1:0] BEAT_LAST_W1 = 3'h7;
  localparam logic [BEAT_W-1:0] BEAT_LAST_W2 = 3'h3;
  localparam logic [BEAT_W-1:0] BEAT_LAST_W4 = 3'h1;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hf;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_QE = 1'b0;
  localparam logic RST_HOLD_SEL = 1'b1;
  localparam logic RST_FOUR_LANE = 1'b0;

  typedef enum logic [1:0] {QSF_W1, QSF_W2, QSF_W4} qsf_width_t;
  typedef enum logic [1:0] {QSF_ERASE_SECTOR, QSF_ERASE_BLK32, QSF_ERASE_BLK64,
                            QSF_ERASE_CHIP} qsf_erase_t;

endpackage

// ### testbench/qsf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module qsf_host_model (
  output logic sclk, // Serial clock
  output logic csN, // Chip select
  output logic d0, // Host drive on lane 0
  input wire logic d1 // Lane 1 level
);
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    d0 = 1'b1;
  end
  // ****************************************************************
  // Mode 0 frames: clock idles low and stands still between frames
  // ****************************************************************
  task automatic frame(input logic on);
    csN = !on;
    #5;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      d0 = tx[i];
      #3 sclk = 1'b1;
      rx[i] = d1;
      #3 sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/qsf_pin_io_chk.sv
`timescale 1ns/1ns
`default_nettype none
module qsf_pin_io_chk
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic csN, // Select
  input wire logic ioLane0Oe, // Enable 0
  input wire logic ioLane1Oe, // Enable 1
  input wire logic ioLane2Oe, // Enable 2
  input wire logic ioLane3Oe, // Enable 3
  input wire logic quadLanesEnable, // Quad bit
  input wire logic statusWrReq, // Status ask
  input wire logic statusWrGrant, // Granted
  input wire logic statusWrDenied, // Denied
  input wire logic mapValid, // Map ask
  input wire logic [qsf_pkg::ADDR_W-1:0] mapAddr, // Map address
  input wire qsf_pkg::qsf_erase_t mapKind, // Map unit
  input wire logic mapDone, // Map answer
  input wire logic [qsf_pkg::ADDR_W-1:0] eraseBase, // Unit start
  input wire logic [qsf_pkg::ADDR_W-1:0] eraseLast, // Unit end
  input wire logic progStart, // Program start
  input wire logic progByteValid, // Program byte
  input wire logic [7:0] progOld, // Old byte
  input wire logic [7:0] progNew, // New byte
  input wire logic progOutValid, // Merged valid
  input wire logic [7:0] progMerged, // Merged byte
  input wire logic progRefused // Over limit
);
  import qsf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  lanes_float_a: assert property (csN |-> !(ioLane0Oe | ioLane1Oe | ioLane2Oe | ioLane3Oe))
    else $error("lane driven while deselected");
  status_answer_a: assert property (statusWrReq |=> statusWrGrant != statusWrDenied)
    else $error("status write answer wrong");
  guard_ignored_a: assert property (statusWrReq && csN && quadLanesEnable
    && $past(quadLanesEnable, 8) |=> !statusWrDenied) else $error("guard acted in quad mode");
  map_answer_a: assert property (mapValid |=> mapDone)
    else $error("map answer missing");
  sector_span_a: assert property (mapValid && mapKind == QSF_ERASE_SECTOR |=>
    eraseBase == {$past(mapAddr[23:12]), 12'h000} && eraseLast[11:0] == 12'hfff)
    else $error("sector span wrong");
  blk64_span_a: assert property (mapValid && mapKind == QSF_ERASE_BLK64 |=>
    eraseBase == {$past(mapAddr[23:16]), 16'h0000} && eraseLast[15:0] == 16'hffff)
    else $error("64 KB span wrong");
  chip_span_a: assert property (mapValid && mapKind == QSF_ERASE_CHIP |=>
    eraseBase == 24'h000000 && eraseLast == ADDR_LAST) else $error("chip span wrong");
  prog_merge_a: assert property (progByteValid ##1 progOutValid |->
    progMerged == ($past(progOld) & $past(progNew))) else $error("merge not an and");
  prog_either_a: assert property (progByteValid && !progStart |=>
    progOutValid != progRefused) else $error("program byte answer wrong");
endmodule
bind qsf_pin_io qsf_pin_io_chk i_qsf_pin_io_chk (.clk(clk), .rst_n(rst_n), .csN(csN),
  .ioLane0Oe(ioLane0Oe), .ioLane1Oe(ioLane1Oe), .ioLane2Oe(ioLane2Oe), .ioLane3Oe(ioLane3Oe),
  .quadLanesEnable(quadLanesEnable), .statusWrReq(statusWrReq),
  .statusWrGrant(statusWrGrant), .statusWrDenied(statusWrDenied), .mapValid(mapValid),
  .mapAddr(mapAddr), .mapKind(mapKind), .mapDone(mapDone), .eraseBase(eraseBase),
  .eraseLast(eraseLast), .progStart(progStart), .progByteValid(progByteValid),
  .progOld(progOld), .progNew(progNew), .progOutValid(progOutValid),
  .progMerged(progMerged), .progRefused(progRefused));
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import qsf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, quadLanesEnable = 1'b0, holdSelect = 1'b1;
  logic wordValid = 1'b0, statusWrReq = 1'b0, mapValid = 1'b0, progStart = 1'b0;
  logic progByteValid = 1'b0, guardPin = 1'b1, pausePin = 1'b1, fourLane = 1'b0;
  logic [7:0] wordData = 8'h00, progOld = 8'h00, progNew = 8'h00, rxByte, progMerged;
  logic [ADDR_W-1:0] mapAddr = 24'h000000, progAddr = 24'h000000;
  logic [ADDR_W-1:0] eraseBase, eraseLast, progOutAddr;
  qsf_erase_t mapKind = QSF_ERASE_SECTOR;
  qsf_width_t wordWidth = QSF_W1;
  logic o0, e0, o1, e1, o2, e2, o3, e3, wordReady, rxValid, frameActive, mapDone, wordRefused;
  logic statusWrGrant, statusWrDenied, deviceReset, progOutValid, progRefused, statusWrBlocked;
  logic [PAGE_IDX_W-1:0] pageIndex;
  logic [SECTOR_IDX_W-1:0] sectorIndex;
  logic [BLK32_IDX_W-1:0] blk32Index;
  logic [BLK64_IDX_W-1:0] blk64Index;
  int miscompares = 0, samplesChecked = 0;
  wire logic sclk, csN, hostD0;
  wire logic pin0 = e0 ? o0 : hostD0;
  // Lane 1 has no pull-up: while released it shows the inverse of the lane 1 drive value
  wire logic pin1 = e1 ? o1 : ~o1;
  wire logic pin2 = e2 ? o2 : guardPin;
  wire logic pin3 = e3 ? o3 : pausePin;
  always #2 clk = ~clk;
  qsf_host_model i_qsf_host_model (.sclk(sclk), .csN(csN), .d0(hostD0), .d1(pin1));
  qsf_pin_io i_qsf_pin_io (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
    .ioLane0In(pin0), .ioLane0Out(o0), .ioLane0Oe(e0), .ioLane1In(pin1), .ioLane1Out(o1),
    .ioLane1Oe(e1), .ioLane2In(pin2), .ioLane2Out(o2), .ioLane2Oe(e2), .ioLane3In(pin3),
    .ioLane3Out(o3), .ioLane3Oe(e3), .quadLanesEnable(quadLanesEnable),
    .holdSelect(holdSelect), .fourLaneCommandMode(fourLane), .wordValid(wordValid),
    .wordData(wordData), .wordWidth(wordWidth), .wordDrive(1'b1), .wordReady(wordReady),
    .wordRefused(wordRefused), .rxValid(rxValid), .rxByte(rxByte), .frameActive(frameActive),
    .statusWrReq(statusWrReq), .statusWrGrant(statusWrGrant),
    .statusWrDenied(statusWrDenied), .statusWrBlocked(statusWrBlocked), .deviceReset(deviceReset),
    .mapValid(mapValid), .mapAddr(mapAddr), .mapKind(mapKind), .mapDone(mapDone),
    .pageIndex(pageIndex), .sectorIndex(sectorIndex), .blk32Index(blk32Index),
    .blk64Index(blk64Index), .eraseBase(eraseBase), .eraseLast(eraseLast),
    .progStart(progStart), .progAddr(progAddr), .progByteValid(progByteValid),
    .progOld(progOld), .progNew(progNew), .progOutValid(progOutValid),
    .progMerged(progMerged), .progOutAddr(progOutAddr), .progRefused(progRefused));
  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_map();
    int shifts[4] = '{12, 15, 16, 24};
    logic [23:0] a, b;
    for (int n = 0; n < 8; n++)
    begin
      a = n < 4 ? 24'h8f3a5c : 24'hffffff;
      b = (a >> shifts[n % 4]) << shifts[n % 4];
      @(negedge clk);
      mapValid = 1'b1;
      mapAddr = a;
      mapKind = qsf_erase_t'(n[1:0]);
      @(negedge clk);
      mapValid = 1'b0;
      chk(mapDone, 1'b1);
      chk(eraseBase, b);
      chk(eraseLast, b | ((32'h1 << shifts[n % 4]) - 1));
      chk(pageIndex, a >> 8);
      chk({sectorIndex, blk32Index, blk64Index}, {a[23:12], a[23:15], a[23:16]});
    end
    $display("map test over");
  endtask
  task automatic t_prog();
    @(negedge clk);
    progByteValid = 1'b1;
    @(negedge clk);
    progByteValid = 1'b0;
    chk(progRefused, 1'b1);
    progStart = 1'b1;
    progAddr = 24'h1234f0;
    @(negedge clk);
    progStart = 1'b0;
    for (int i = 0; i <= 256; i++)
    begin
      progByteValid = 1'b1;
      progOld = i[7:0];
      progNew = 8'h5a ^ i[7:0];
      @(negedge clk);
      progByteValid = 1'b0;
      chk({progOutValid, progRefused}, {i < 256, i == 256});
      if (i < 256)
        chk({progMerged, progOutAddr}, {i[7:0] & progNew, 16'h1234, 8'hf0 + i[7:0]});
      @(negedge clk);
    end
    $display("program test over");
  endtask
  task automatic sw(input logic qe, input logic guard, input logic expDen);
    quadLanesEnable = qe;
    guardPin = guard;
    repeat (8) @(negedge clk);
    statusWrReq = 1'b1;
    @(negedge clk);
    statusWrReq = 1'b0;
    chk({statusWrBlocked, statusWrDenied, statusWrGrant}, {{2{expDen}}, !expDen});
  endtask
  task automatic t_link();
    logic [7:0] rx;
    int seen = 0;
    fourLane = 1'b1;
    i_qsf_host_model.frame(1'b1);
    fork
      i_qsf_host_model.xfer(8'h3c, rx);
      begin
        repeat (4) @(negedge clk);
        chk({frameActive, wordReady}, 2'h3);
        wordValid = 1'b1;
        wordData = 8'ha5;
        wordWidth = QSF_W4;
        @(negedge clk);
        wordValid = 1'b0;
        chk({wordRefused, wordReady}, 2'h2);
      end
    join
    repeat (6) @(negedge clk) seen += rxValid;
    chk({seen[3:0], rxByte}, {4'h1, 8'h3c});
    i_qsf_host_model.xfer(8'h00, rx);
    chk({rx, e0}, {8'ha5, 1'b0});
    i_qsf_host_model.frame(1'b0);
    chk({e0, e1, e2, e3}, 4'h0);
    $display("link test over");
  endtask
  task automatic t_rstpin();
    @(negedge clk);
    holdSelect = 1'b0;
    pausePin = 1'b0;
    repeat (8) @(negedge clk);
    chk(deviceReset, 1'b1);
    quadLanesEnable = 1'b1;
    repeat (8) @(negedge clk);
    chk(deviceReset, 1'b0);
    $display("reset pin test over");
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_map();
    t_prog();
    sw(1'b0, 1'b0, 1'b1);
    sw(1'b0, 1'b1, 1'b0);
    sw(1'b1, 1'b0, 1'b0);
    sw(1'b0, 1'b1, 1'b0);
    $display("status test over");
    t_link();
    t_rstpin();
    results();
  end
  // Tests need about 630 cycles; give several times that before giving up
  initial
  begin
    #20000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
